// ==== hw/config_word_decoder.sv ====
// configuration word latch, decode, pin muxing and erase sequencing
// Summary of operation
// - 2K part: pair 11 none, 10 0400h-07FFh, 01 0200h-07FFh, 00 all.
// - 1K part: 11 and 10 none, 01 0200h-03FFh, 00 0000h-03FFh.
// - clearing enabled code protection erases all program memory.
// - bit 8 low protects data memory, high leaves it open.
// - turning data protection off erases data memory, not calibration.
// - bit 7 high gives shared program pin its entry function, else input.
// - bit 6 enables brown-out detect reset.
// - brown-out enabled forces power-up timer on.
// - bit 5 high makes shared reset pin external reset, else input.
// - bit 3 low enables power-up timer.
// - bit 2 enables watchdog timer.
// - oscillator field bits 4,1,0; 111/110 external resistor mode.
// - 101/100 internal RC, input pin I/O, 101 gives clock-out.
// - 011 external clock on input pin, output pin I/O.
// - 010, 001, 000 select high-speed, standard, low-power crystal.
// - external reset held in RC or resistor mode stops internal oscillator.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder #(
  parameter bit small_memory = 1'b0,
  parameter int cfg_bits = 14
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic resetn,
  // word from the non-volatile cell
  input wire logic [13:0] nv_config_word,
  // shared pins
  input wire logic shared_reset_pin,
  input wire logic shared_program_pin,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // decoded controls
  output cfg_word_pkg::cfg_controls_t controls,
  output logic external_reset_asserted,
  output logic lv_program_request,
  output logic shared_reset_pin_data,
  output logic shared_program_pin_data,
  output logic internal_osc_run,
  // erase requests to the memories
  output cfg_word_pkg::erase_req_t erase_req,
  input wire logic erase_done
);
  // the decode tables only serve the 14-bit word
  if (cfg_bits != cfg_word_pkg::cfg_width) begin
    $error("config word width must be 14");
  end

  typedef struct packed {
    logic loaded;
    logic [13:0] word;
    logic [13:0] pending;
    cfg_word_pkg::cfg_controls_t ctl;
    logic [2:0] rst_sync;
    logic [2:0] pgm_sync;
    logic rst_level;
    logic pgm_level;
    logic data_phase;
    logic data_write;
    logic [15:0] data_addr;
    logic [31:0] rdata;
    cfg_word_pkg::erase_req_t erase;
    logic busy;
  } state_t;

  state_t state;
  state_t next_state;
  cfg_word_pkg::cfg_controls_t dec_now;
  cfg_word_pkg::cfg_controls_t dec_pend;
  logic code_clearing;
  logic data_clearing;

  // decoders on the live and the pending word; the pair shows what would clear
  cfg_word_field_decode #(.small_memory(small_memory)) u_dec_now (
    .cfg_word(state.word),
    .controls(dec_now)
  );
  cfg_word_field_decode #(.small_memory(small_memory)) u_dec_pend (
    .cfg_word(state.pending),
    .controls(dec_pend)
  );

  assign code_clearing = state.ctl.code.active & ~dec_pend.code.active;
  assign data_clearing = state.ctl.data_protect & ~dec_pend.data_protect;

  // next-state logic
  always_comb begin
    next_state = state;
    // three-stage pin synchronisers, change accepted when last two agree
    next_state.rst_sync = {state.rst_sync[1:0], shared_reset_pin};
    next_state.pgm_sync = {state.pgm_sync[1:0], shared_program_pin};
    if (state.rst_sync[2] == state.rst_sync[1]) begin
      next_state.rst_level = state.rst_sync[2];
    end
    if (state.pgm_sync[2] == state.pgm_sync[1]) begin
      next_state.pgm_level = state.pgm_sync[2];
    end
    // single capture after release keeps the word frozen until next reset
    if (!state.loaded) begin
      next_state.loaded = 1'b1;
      next_state.word = nv_config_word;
      next_state.pending = nv_config_word;
    end else begin
      next_state.ctl = dec_now;
    end
    // ahb address phase
    next_state.data_phase = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_state.data_phase = 1'b1;
      next_state.data_write = hwrite;
      next_state.data_addr = haddr;
      next_state.rdata = '0;
      case (haddr)
        cfg_word_pkg::device_configuration_word_addr:
          next_state.rdata = {18'h00000, state.word};
        cfg_word_pkg::erase_control_addr:
          next_state.rdata = {18'h00000, state.pending};
        cfg_word_pkg::status_addr:
          next_state.rdata = {29'h00000000, state.busy, state.erase};
        default: next_state.rdata = '0;
      endcase
    end
    // write of a candidate word: stored as pending until next power-on
    if (state.data_phase && state.data_write && !state.busy &&
        state.data_addr == cfg_word_pkg::erase_control_addr) begin
      next_state.pending = hwdata[13:0];
    end
    // erase sequencing when the pending word drops protection
    if (!state.busy && state.loaded && (code_clearing || data_clearing)) begin
      next_state.busy = 1'b1;
      next_state.erase.program_erase = code_clearing;
      next_state.erase.data_erase = data_clearing;
    end else if (state.busy && erase_done) begin
      next_state.busy = 1'b0;
      next_state.erase = '0;
      // record protection as gone so the erase is not repeated
      next_state.ctl.code.active = dec_pend.code.active;
      next_state.ctl.data_protect = dec_pend.data_protect;
    end
    if (state.busy && !erase_done) begin
      next_state.ctl.code.active = state.ctl.code.active;
      next_state.ctl.data_protect = state.ctl.data_protect;
    end
    if (!state.busy && state.loaded && !code_clearing && !data_clearing &&
        state.ctl != '0 && state.pending != state.word) begin
      next_state.ctl.code.active = state.ctl.code.active;
      next_state.ctl.data_protect = state.ctl.data_protect;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
      // reset pin idles high: start its sync there, else a false reset follows
      state.rst_sync <= 3'h7;
      state.rst_level <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // bus answers: zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state.rdata;

  // registered decoded controls
  assign controls = state.ctl;
  assign erase_req = state.erase;

  // shared reset pin: external reset only when selected, else tied inactive
  assign external_reset_asserted = state.ctl.external_reset_input_used
                                   & ~state.rst_level;
  assign shared_reset_pin_data = state.ctl.external_reset_input_used ? 1'b0
                                 : state.rst_level;
  // shared program pin: entry function or plain input
  assign lv_program_request = state.ctl.lv_program_entry & state.pgm_level;
  assign shared_program_pin_data = state.ctl.lv_program_entry ? 1'b0
                                   : state.pgm_level;
  // rc and resistor oscillators halt while reset is held
  assign internal_osc_run = state.loaded
    & (state.ctl.osc_mode == cfg_word_pkg::internal_rc_mode
       || state.ctl.osc_mode == cfg_word_pkg::ext_resistor_mode)
    & ~external_reset_asserted;
endmodule
`default_nettype wire

// ==== hw/cfg_word_pkg.sv ====
// constants and carrier types for the configuration word decoder
package cfg_word_pkg;
  // register map (word index; byte address is four times it)
  localparam logic [15:0] device_configuration_word_index = 16'h2007;
  localparam logic [15:0] device_configuration_word_addr = 16'h801C;
  localparam logic [15:0] erase_control_addr = 16'h8020;
  localparam logic [15:0] status_addr = 16'h8024;
  // field positions of the 14-bit word
  localparam int cfg_width = 14;
  localparam int pos_pair_a = 12;
  localparam int pos_pair_b = 10;
  localparam int pos_data_protect = 8;
  localparam int pos_low_volt_prog = 7;
  localparam int pos_brownout = 6;
  localparam int pos_reset_pin = 5;
  localparam int pos_osc_high = 4;
  localparam int pos_powerup_n = 3;
  localparam int pos_watchdog = 2;
  localparam int pos_osc_low = 0;
  // erased word: protections off, but watchdog, brown-out, power-up timer and low-voltage entry on
  localparam logic [13:0] cfg_reset_value = 14'h3FFF;
  // protection bounds
  localparam logic [10:0] top_2k = 11'h7FF;
  localparam logic [10:0] top_1k = 11'h3FF;
  localparam logic [10:0] base_all = 11'h000;
  localparam logic [10:0] base_half_2k = 11'h400;
  localparam logic [10:0] base_quarter = 11'h200;
  // oscillator codes
  localparam logic [2:0] osc_er_clkout = 3'h7;
  localparam logic [2:0] osc_er_io = 3'h6;
  localparam logic [2:0] osc_int_clkout = 3'h5;
  localparam logic [2:0] osc_int_io = 3'h4;
  localparam logic [2:0] osc_ext_clock = 3'h3;
  localparam logic [2:0] osc_hs = 3'h2;
  localparam logic [2:0] osc_xt = 3'h1;
  localparam logic [2:0] osc_lp = 3'h0;

  typedef enum logic [6:0] {
    ext_resistor_mode = 7'h01,
    internal_rc_mode = 7'h02,
    external_clock_mode = 7'h04,
    high_speed_crystal_mode = 7'h08,
    standard_crystal_mode = 7'h10,
    low_power_crystal_mode = 7'h20,
    osc_off_mode = 7'h40
  } osc_mode_t;

  // protected range of program memory
  typedef struct packed {
    logic active;
    logic [10:0] low;
    logic [10:0] high;
  } protect_range_t;

  // decoded static controls
  typedef struct packed {
    protect_range_t code;
    logic data_protect;
    logic lv_program_entry;
    logic brownout_reset_enable;
    logic external_reset_input_used;
    logic powerup_timer;
    logic watchdog_enable;
    osc_mode_t osc_mode;
    logic clkout_on_output_pin;
    logic output_pin_is_io;
    logic input_pin_is_io;
  } cfg_controls_t;

  // erase requests toward the memories
  typedef struct packed {
    logic program_erase;
    logic data_erase;
  } erase_req_t;
endpackage

// ==== hw/cfg_word_field_decode.sv ====
// combinational decode of one configuration word into static controls
`timescale 1ns/1ps
`default_nettype none
module cfg_word_field_decode #(
  parameter bit small_memory = 1'b0
) (
  // word in
  input wire logic [13:0] cfg_word,
  // decoded controls out
  output cfg_word_pkg::cfg_controls_t controls
);
  logic [1:0] pair_a;
  logic [1:0] pair_b;
  logic [2:0] osc_mode_field;

  // field extraction
  assign pair_a = cfg_word[cfg_word_pkg::pos_pair_a +: 2];
  assign pair_b = cfg_word[cfg_word_pkg::pos_pair_b +: 2];
  assign osc_mode_field = {cfg_word[cfg_word_pkg::pos_osc_high],
                           cfg_word[cfg_word_pkg::pos_osc_low +: 2]};

  // decode tables
  always_comb begin
    controls = '0;
    controls.osc_mode = cfg_word_pkg::osc_off_mode;
    // mismatched pairs leave memory unprotected
    if (pair_a == pair_b) begin
      if (!small_memory) begin
        controls.code.high = cfg_word_pkg::top_2k;
        case (pair_a)
          2'h2: begin
            controls.code.active = 1'b1;
            controls.code.low = cfg_word_pkg::base_half_2k;
          end
          2'h1: begin
            controls.code.active = 1'b1;
            controls.code.low = cfg_word_pkg::base_quarter;
          end
          2'h0: begin
            controls.code.active = 1'b1;
            controls.code.low = cfg_word_pkg::base_all;
          end
          default: controls.code.active = 1'b0;
        endcase
      end else begin
        controls.code.high = cfg_word_pkg::top_1k;
        case (pair_a)
          2'h1: begin
            controls.code.active = 1'b1;
            controls.code.low = cfg_word_pkg::base_quarter;
          end
          2'h0: begin
            controls.code.active = 1'b1;
            controls.code.low = cfg_word_pkg::base_all;
          end
          default: controls.code.active = 1'b0;
        endcase
      end
    end
    controls.data_protect = ~cfg_word[cfg_word_pkg::pos_data_protect];
    controls.lv_program_entry = cfg_word[cfg_word_pkg::pos_low_volt_prog];
    controls.brownout_reset_enable = cfg_word[cfg_word_pkg::pos_brownout];
    controls.external_reset_input_used = cfg_word[cfg_word_pkg::pos_reset_pin];
    // brown-out forces the timer on regardless of its own bit
    controls.powerup_timer = ~cfg_word[cfg_word_pkg::pos_powerup_n]
                             | cfg_word[cfg_word_pkg::pos_brownout];
    controls.watchdog_enable = cfg_word[cfg_word_pkg::pos_watchdog];
    case (osc_mode_field)
      cfg_word_pkg::osc_er_clkout: begin
        controls.osc_mode = cfg_word_pkg::ext_resistor_mode;
        controls.clkout_on_output_pin = 1'b1;
      end
      cfg_word_pkg::osc_er_io: begin
        controls.osc_mode = cfg_word_pkg::ext_resistor_mode;
        controls.output_pin_is_io = 1'b1;
      end
      cfg_word_pkg::osc_int_clkout: begin
        controls.osc_mode = cfg_word_pkg::internal_rc_mode;
        controls.clkout_on_output_pin = 1'b1;
        controls.input_pin_is_io = 1'b1;
      end
      cfg_word_pkg::osc_int_io: begin
        controls.osc_mode = cfg_word_pkg::internal_rc_mode;
        controls.output_pin_is_io = 1'b1;
        controls.input_pin_is_io = 1'b1;
      end
      cfg_word_pkg::osc_ext_clock: begin
        controls.osc_mode = cfg_word_pkg::external_clock_mode;
        controls.output_pin_is_io = 1'b1;
      end
      cfg_word_pkg::osc_hs: controls.osc_mode = cfg_word_pkg::high_speed_crystal_mode;
      cfg_word_pkg::osc_xt: controls.osc_mode = cfg_word_pkg::standard_crystal_mode;
      default: controls.osc_mode = cfg_word_pkg::low_power_crystal_mode;
    endcase
  end
endmodule
`default_nettype wire

// ==== dv/cfg_word_chk.sv ====
// assertion checker for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cfg_word_chk #(
  parameter bit small_memory = 1'b0,
  parameter int cfg_bits = 14
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cfg_word_pkg::cfg_controls_t controls,
  input wire logic external_reset_asserted,
  input wire logic lv_program_request,
  input wire logic shared_reset_pin_data,
  input wire logic shared_program_pin_data,
  input wire logic internal_osc_run,
  input wire cfg_word_pkg::erase_req_t erase_req,
  input wire logic erase_done
);
  logic [1:0] age;
  wire rc_like = controls.osc_mode inside {cfg_word_pkg::internal_rc_mode,
    cfg_word_pkg::ext_resistor_mode};
  wire xtal = controls.osc_mode inside {cfg_word_pkg::high_speed_crystal_mode,
    cfg_word_pkg::standard_crystal_mode, cfg_word_pkg::low_power_crystal_mode};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // edges since reset release; controls settle at the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  chk_prog_erase_hold: assert property (erase_req.program_erase && !erase_done |=>
    erase_req.program_erase) else $error("program erase dropped early");
  chk_data_erase_hold: assert property (erase_req.data_erase && !erase_done |=>
    erase_req.data_erase) else $error("data erase dropped early");
  chk_mode_static: assert property (age == 2'h3 |-> $stable(controls.osc_mode) &&
    $stable(controls.watchdog_enable)) else $error("static control moved");
  chk_bor_powerup_timer: assert property (controls.brownout_reset_enable |-> controls.powerup_timer)
    else $error("power-up timer not forced");
  chk_osc_stop: assert property ($past(external_reset_asserted) && external_reset_asserted
    |-> !internal_osc_run) else $error("oscillator runs in reset");
  chk_osc_run_mode: assert property (internal_osc_run |-> rc_like)
    else $error("oscillator runs in wrong mode");
  chk_reset_pin: assert property (external_reset_asserted |->
    controls.external_reset_input_used && !shared_reset_pin_data) else $error("reset pin misuse");
  chk_lv_entry: assert property (lv_program_request |->
    controls.lv_program_entry && !shared_program_pin_data) else $error("program pin misuse");
  chk_clkout_mode: assert property (controls.clkout_on_output_pin |-> rc_like)
    else $error("clock-out in wrong mode");
  chk_xtal_pins: assert property (xtal |-> !controls.output_pin_is_io &&
    !controls.input_pin_is_io) else $error("crystal pin released");
endmodule
bind config_word_decoder cfg_word_chk #(.small_memory(small_memory), .cfg_bits(cfg_bits)) chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
  .controls(controls), .external_reset_asserted(external_reset_asserted),
  .lv_program_request(lv_program_request), .shared_reset_pin_data(shared_reset_pin_data),
  .shared_program_pin_data(shared_program_pin_data), .internal_osc_run(internal_osc_run),
  .erase_req(erase_req), .erase_done(erase_done));
`default_nettype wire

// ==== dv/cfg_prog_model.sv ====
// programmer and memory model: supplies the word, answers erase requests
`timescale 1ns/1ps
`default_nettype none
module cfg_prog_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // burnt word and erase duration
  input wire logic [13:0] prog_word,
  input wire logic [7:0] erase_delay,
  output logic [13:0] nv_config_word,
  // erase handshake
  input wire cfg_word_pkg::erase_req_t erase_req,
  output logic erase_done
);
  logic [7:0] cnt;
  // programmer passes the test's word through unchanged, matched or split protect pairs alike
  assign nv_config_word = prog_word;
  // slow memory: a bulk erase takes one cycle more than the set delay
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      erase_done <= 1'b0;
    end else if (erase_req != 2'b00 && !erase_done && cnt == erase_delay) begin
      cnt <= 8'h00;
      erase_done <= 1'b1;
    end else begin
      cnt <= (erase_req != 2'b00 && !erase_done) ? cnt + 8'h01 : 8'h00;
      erase_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, resetn, hsel, hwrite, spin, ppin, hreadyout, hresp, done;
  logic lvreq, rpd, ppd, erst, orun, erst1, orun1;
  logic [15:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [13:0] word, nvw;
  logic [10:0] lo;
  int error_cnt, compares, i;
  cfg_word_pkg::cfg_controls_t c, k;
  cfg_word_pkg::erase_req_t er;
  cfg_word_pkg::osc_mode_t m;
  // field words: all on, all off, brown-out off with timer bit set
  logic [13:0] word_tab [3] = '{14'h3FEC, 14'h3E00, 14'h3FAC};
  logic [8:0] exp_tab [3] = '{9'h0FC, 9'h113, 9'h0AC};
  config_word_decoder dut_u (.ref_clk(ref_clk), .resetn(resetn), .nv_config_word(nvw),
    .shared_reset_pin(spin), .shared_program_pin(ppin), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .controls(c),
    .external_reset_asserted(erst), .lv_program_request(lvreq), .shared_reset_pin_data(rpd),
    .shared_program_pin_data(ppd), .internal_osc_run(orun), .erase_req(er), .erase_done(done));
  // 1K variant sees the same word and pins
  config_word_decoder #(.small_memory(1'b1)) dut_1k_u (.ref_clk(ref_clk), .resetn(resetn),
    .nv_config_word(nvw), .shared_reset_pin(spin), .shared_program_pin(ppin), .hsel(1'b0),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(1'b1), .hreadyout(), .hresp(), .hrdata(), .controls(k),
    .external_reset_asserted(erst1), .lv_program_request(), .shared_reset_pin_data(),
    .shared_program_pin_data(), .internal_osc_run(orun1), .erase_req(), .erase_done(1'b0));
  cfg_prog_model prog_u (.ref_clk(ref_clk), .resetn(resetn), .prog_word(word),
    .erase_delay(8'h1E), .nv_config_word(nvw), .erase_req(er), .erase_done(done));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single ahb-lite transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    q = hrdata;
  endtask
  task automatic rd(input string n, input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, e, q);
  endtask
  // power-on with a freshly programmed word, extra edges for the pin syncs
  task automatic power_on(input logic [13:0] w);
    word <= w;
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  initial begin
    #1ms;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {resetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    {spin, ppin, hsize, word} = {2'b11, 3'b010, 14'h3FFF};
    @(posedge ref_clk);
    for (int p = 0; p < 4; p++) begin
      power_on({p[1:0], p[1:0], 10'h3FF});
      lo = (p == 2) ? 11'h400 : (p == 1) ? 11'h200 : 11'h000;
      check("active_2k", p != 3, c.code.active);
      if (p != 3) check("range_2k", {lo, 11'h7FF}, {c.code.low, c.code.high});
      check("active_1k", p < 2, k.code.active);
      if (p < 2) check("range_1k", {lo, 11'h3FF}, {k.code.low, k.code.high});
    end
    power_on(14'h33FF);
    check("active_split", 1'b0, c.code.active);
    foreach (word_tab[j]) begin
      power_on(word_tab[j]);
      check("fields", exp_tab[j], {c.data_protect, c.lv_program_entry,
        c.brownout_reset_enable, c.external_reset_input_used, c.powerup_timer,
        c.watchdog_enable, lvreq, rpd, ppd});
      rd("word_reg", 16'h801C, {18'h0, word_tab[j]});
    end
    for (int o = 0; o < 8; o++) begin
      power_on({4'hF, 5'b10001, o[2], 2'b00, o[1:0]});
      case (o)
        7, 6: m = cfg_word_pkg::ext_resistor_mode;
        5, 4: m = cfg_word_pkg::internal_rc_mode;
        3: m = cfg_word_pkg::external_clock_mode;
        2: m = cfg_word_pkg::high_speed_crystal_mode;
        1: m = cfg_word_pkg::standard_crystal_mode;
        default: m = cfg_word_pkg::low_power_crystal_mode;
      endcase
      check("osc_mode", m, c.osc_mode);
      check("osc_pins", {o == 7 || o == 5, o == 6 || o == 4 || o == 3, o == 5 || o == 4},
        {c.clkout_on_output_pin, c.output_pin_is_io, c.input_pin_is_io});
      check("osc_run", o >= 4, orun);
      spin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("osc_stop", 2'b10, {erst, orun});
      spin <= 1'b1;
      repeat (6) @(posedge ref_clk);
    end
    // protected part, then a bus write of a pending word clears both protections
    power_on(14'h02EC);
    check("protected", 2'b11, {c.code.active, c.data_protect});
    rd("unmapped", 16'h8000, 32'h0);
    bus(1'b1, 16'h801C, 32'h0);
    rd("word_ro", 16'h801C, 32'h02EC);
    bus(1'b1, 16'h8020, 32'h3FEC);
    rd("pending", 16'h8020, 32'h3FEC);
    for (i = 0; i < 20 && er !== 2'b11; i++) @(posedge ref_clk);
    check("erase_req", 2'b11, er);
    rd("status_busy", 16'h8024, 32'h7);
    for (i = 0; i < 100 && er !== 2'b00; i++) @(posedge ref_clk);
    rd("status_idle", 16'h8024, 32'h0);
    check("unprotected", 3'b001, {c.code.active, c.data_protect, c.watchdog_enable});
    rd("word_kept", 16'h801C, 32'h02EC);
    give_verdict();
  end
endmodule
`default_nettype wire
